// [rtl/counter_config.sv]
// counter, prescaler and configuration register with avalon slave
`timescale 1ns/1ps
module counter_config #(
  parameter int unsigned CNT_W = 8
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire cfg_pkg::av_req_s av_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic configuration_word_a_extend_enable_in,
  input wire logic turbo_in,
  input wire logic count_pin_in,
  input wire logic wdt_timeout_in,
  input wire logic [7:0] accumulator_in,
  output logic map_select_out,
  output logic [7:0] file01_out,
  output logic wdt_reset_out,
  output logic rollover_irq_out,
  output logic irq_out
);
  import cfg_pkg::*;

  config_s cfg_reg;
  config_s cfg_next;
  logic [CNT_W-1:0] counter_reg;
  logic [7:0] presc_reg;
  logic [2:0] icyc_reg;
  logic [1:0] sync_reg;
  logic pin_prev_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic [1:0] entry_reg;
  logic entry_busy_reg;
  logic wdt_reset_reg;

  wire access = av_in.read | av_in.write;
  wire wr = av_in.write & ack_reg;
  // read data captured in the wait cycle so it stands at the completing edge
  wire rd = av_in.read & ~ack_reg;
  wire sel_cfg = av_in.address == OFS_CONFIG;
  wire sel_cnt = av_in.address == OFS_COUNTER;
  wire sel_st = av_in.address == OFS_STATUS;
  wire sel_mask = av_in.address == OFS_MASK;
  wire [7:0] wd8 = av_in.writedata[7:0];

  // instruction cycle enable [RL13]
  wire icyc_tick = turbo_in | (icyc_reg == COMPAT_DIV_LAST);
  // pin edge after synchroniser [RL15] [RL7]
  wire pin_s = sync_reg[1];
  wire pin_edge = cfg_reg.polarity ? (pin_prev_reg & ~pin_s) : (~pin_prev_reg & pin_s);
  // counter source [RL6]
  wire src_tick = cfg_reg.source_select ? pin_edge : icyc_tick;
  // divider mask: factor 2^(ps+1) for counter [RL10], 2^ps timeouts for watchdog [RL11]
  wire [7:0] cnt_lim = 8'(({1'b0, 8'hFF} >> (4'h7 - {1'b0, cfg_reg.factor})) );
  wire [7:0] wdt_lim = 8'(cnt_lim >> 1);
  wire presc_wrap_cnt = (presc_reg & cnt_lim) == cnt_lim;
  wire presc_wrap_wdt = (presc_reg & wdt_lim) == wdt_lim;
  // prescaler placement [RL8] [RL9]
  wire cnt_tick = cfg_reg.divider_assign ? src_tick : (src_tick & presc_wrap_cnt);
  wire presc_in = cfg_reg.divider_assign ? wdt_timeout_in : src_tick;
  wire wdt_fire = cfg_reg.divider_assign ? (wdt_timeout_in & presc_wrap_wdt) : wdt_timeout_in;
  wire cnt_max = counter_reg == {CNT_W{1'b1}};
  wire rollover = cnt_tick & cnt_max; // [RL14]
  wire cnt_wr = wr & sel_cnt;

  // writes that clear protected bits need configuration_word_a extend enable low [RL3] [RL5]
  always_comb begin
    cfg_next = cfg_reg;
    if (wr && sel_cfg) begin
      cfg_next = config_s'(wd8);
      if (configuration_word_a_extend_enable_in) begin
        cfg_next.map_select = 1'b1;
        cfg_next.irq_disable = 1'b1;
      end
    end
  end

  wire [1:0] events = {wdt_fire, rollover};
  wire [1:0] st_clear = (wr && sel_st) ? av_in.writedata[1:0] : 2'h0;
  wire [1:0] st_next = (status_reg & ~st_clear) | events;

  wire [31:0] rmux = sel_cfg ? {24'h0, cfg_reg} :
                     sel_cnt ? 32'(counter_reg) :
                     sel_st ? {30'h0, status_reg} :
                     sel_mask ? {30'h0, mask_reg} : 32'h0;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cfg_reg <= config_s'(CONFIG_RESET); // [RL1]
      icyc_reg <= 3'h0;
      sync_reg <= 2'h0;
      pin_prev_reg <= 1'b0;
      status_reg <= 2'h0;
      mask_reg <= MASK_RESET;
      rdata_reg <= 32'h0;
      ack_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      icyc_reg <= icyc_tick ? 3'h0 : icyc_reg + 3'h1;
      sync_reg <= {sync_reg[0], count_pin_in};
      pin_prev_reg <= pin_s;
      status_reg <= st_next;
      if (wr && sel_mask) mask_reg <= av_in.writedata[1:0];
      ack_reg <= access & ~ack_reg;
      if (rd) rdata_reg <= rmux;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      counter_reg <= '0;
      presc_reg <= 8'h0;
    end else begin
      if (cnt_wr) counter_reg <= CNT_W'(wd8);
      else if (cnt_tick) counter_reg <= counter_reg + 1'b1; // [RL14]
      if (cfg_reg.divider_assign ? wdt_fire : cnt_tick) presc_reg <= 8'h0;
      else if (presc_in) presc_reg <= presc_reg + 8'h1;
    end
  end

  // rollover interrupt entry delay in instruction cycles [RL4] [RL12]
  wire roll_req = rollover & ~cfg_reg.irq_disable;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      entry_reg <= 2'h0;
      entry_busy_reg <= 1'b0;
      wdt_reset_reg <= 1'b0;
    end else begin
      wdt_reset_reg <= wdt_fire; // [RL9]
      if (roll_req && !entry_busy_reg) begin
        entry_busy_reg <= 1'b1;
        entry_reg <= 2'h0;
      end else if (entry_busy_reg && icyc_tick) begin
        if (entry_reg == 2'(ENTRY_DELAY - 1)) entry_busy_reg <= 1'b0;
        else entry_reg <= entry_reg + 2'h1;
      end
    end
  end

  // file address 01h selection [RL2]
  always_comb begin
    file01_out = cfg_reg.map_select ? 8'(counter_reg) : accumulator_in;
  end

  assign map_select_out = cfg_reg.map_select;
  assign waitrequest_out = ~ack_reg;
  assign readdata_out = rdata_reg;
  assign wdt_reset_out = wdt_reset_reg;
  assign rollover_irq_out = entry_busy_reg && icyc_tick &&
                            entry_reg == 2'(ENTRY_DELAY - 1); // [RL12]
  assign irq_out = |(status_reg & mask_reg);

  a_cfg_reset_ones: assert property (@(posedge clk_in) $fell(rst_in) |-> cfg_reg == CONFIG_RESET)
    else $error("config not all ones after reset"); // [RL1]
  a_map_file01: assert property (@(posedge clk_in) disable iff (rst_in)
    !map_select_out |-> file01_out == accumulator_in)
    else $error("file 01h not accumulator"); // [RL2]
  a_map_protect: assert property (@(posedge clk_in) disable iff (rst_in)
    configuration_word_a_extend_enable_in && cfg_reg.map_select |=> cfg_reg.map_select)
    else $error("map select cleared while locked"); // [RL3]
  a_irq_protect: assert property (@(posedge clk_in) disable iff (rst_in)
    configuration_word_a_extend_enable_in && cfg_reg.irq_disable |=> cfg_reg.irq_disable)
    else $error("irq disable cleared while locked"); // [RL5]
  a_roll_status: assert property (@(posedge clk_in) disable iff (rst_in)
    rollover |=> status_reg[ST_ROLL] && counter_reg == '0)
    else $error("rollover not flagged"); // [RL14]
  a_irq_suppress: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_reg.irq_disable && !entry_busy_reg |=> !rollover_irq_out)
    else $error("rollover irq while disabled"); // [RL4]
  a_turbo_entry: assert property (@(posedge clk_in) disable iff (rst_in)
    turbo_in && roll_req && !entry_busy_reg ##1 turbo_in [*3] |-> rollover_irq_out)
    else $error("entry delay wrong"); // [RL12]
  a_ext_edge: assert property (@(posedge clk_in) disable iff (rst_in)
    cfg_reg.source_select && cfg_reg.divider_assign && !cnt_wr && !pin_edge
    |=> $stable(counter_reg))
    else $error("counter moved without edge"); // [RL6]
  a_wdt_direct: assert property (@(posedge clk_in) disable iff (rst_in)
    !cfg_reg.divider_assign && wdt_timeout_in |=> wdt_reset_out)
    else $error("watchdog not undivided"); // [RL8]
  a_compat_tick: assert property (@(posedge clk_in) disable iff (rst_in)
    !turbo_in && icyc_tick ##1 !turbo_in |-> !icyc_tick)
    else $error("compatible tick too fast"); // [RL13]

  a_bus_wait_one: assert property (@(posedge clk_in) disable iff (rst_in)
    (av_in.read || av_in.write) && waitrequest_out |=> !waitrequest_out)
    else $error("no answer after one wait cycle");
  a_bus_idle_wait: assert property (@(posedge clk_in) disable iff (rst_in)
    !(av_in.read || av_in.write) |=> waitrequest_out)
    else $error("answer without request");
  a_bus_ack_drop: assert property (@(posedge clk_in) disable iff (rst_in)
    !waitrequest_out |=> waitrequest_out)
    else $error("answer longer than one cycle");
  a_rdata_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    !(av_in.read && waitrequest_out) |=> $stable(readdata_out))
    else $error("read data moved without read");
  a_rdata_cfg: assert property (@(posedge clk_in) disable iff (rst_in)
    av_in.read && waitrequest_out && sel_cfg |=> readdata_out == {24'h0, $past(cfg_reg)})
    else $error("config read data wrong");
  a_rdata_unmapped: assert property (@(posedge clk_in) disable iff (rst_in)
    av_in.read && waitrequest_out && !(sel_cfg || sel_cnt || sel_st || sel_mask)
    |=> readdata_out == 32'h0)
    else $error("unmapped read not zero");

  a_cfg_write_open: assert property (@(posedge clk_in) disable iff (rst_in) // [RL3] [RL5]
    wr && sel_cfg && !configuration_word_a_extend_enable_in |=> cfg_reg == $past(wd8))
    else $error("open config write lost");
  a_cfg_write_lock: assert property (@(posedge clk_in) disable iff (rst_in) // [RL3] [RL5]
    wr && sel_cfg && configuration_word_a_extend_enable_in |=> cfg_reg.map_select && cfg_reg.irq_disable
    && cfg_reg[BIT_SRC:0] == $past(wd8[BIT_SRC:0]))
    else $error("locked config write wrong");
  a_cfg_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    !(wr && sel_cfg) |=> $stable(cfg_reg))
    else $error("config moved without write");
  a_mask_no_write: assert property (@(posedge clk_in) disable iff (rst_in)
    !(wr && sel_mask) |=> $stable(mask_reg))
    else $error("mask moved without write");
  a_file01_counter: assert property (@(posedge clk_in) disable iff (rst_in) // [RL2]
    map_select_out |-> file01_out == counter_reg)
    else $error("file 01h not counter");

  a_cnt_write: assert property (@(posedge clk_in) disable iff (rst_in)
    cnt_wr |=> counter_reg == $past(wd8))
    else $error("counter write lost");
  a_counter_idle: assert property (@(posedge clk_in) disable iff (rst_in) // [RL14]
    !cnt_tick && !cnt_wr |=> $stable(counter_reg))
    else $error("counter moved without tick");
  a_cnt_wrap: assert property (@(posedge clk_in) disable iff (rst_in) // [RL14]
    cnt_tick && cnt_max && !cnt_wr |=> counter_reg == '0)
    else $error("counter did not wrap to zero");
  a_src_pin_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RL6]
    cfg_reg.source_select && !pin_edge && !cnt_wr |=> $stable(counter_reg))
    else $error("pin source counted without edge");
  a_rise_count: assert property (@(posedge clk_in) disable iff (rst_in) // [RL7] [RL15]
    cfg_reg.source_select && cfg_reg.divider_assign && !cfg_reg.polarity && !cnt_wr
    && $rose(pin_s) |=> counter_reg == $past(counter_reg) + 1'b1)
    else $error("rising edge not counted");
  a_fall_count: assert property (@(posedge clk_in) disable iff (rst_in) // [RL7] [RL15]
    cfg_reg.source_select && cfg_reg.divider_assign && cfg_reg.polarity && !cnt_wr
    && $fell(pin_s) |=> counter_reg == $past(counter_reg) + 1'b1)
    else $error("falling edge not counted");
  a_rise_ignored: assert property (@(posedge clk_in) disable iff (rst_in) // [RL7]
    cfg_reg.source_select && cfg_reg.polarity && !$fell(pin_s) && !cnt_wr
    |=> $stable(counter_reg))
    else $error("wrong edge counted");
  a_cycle_count: assert property (@(posedge clk_in) disable iff (rst_in) // [RL6] [RL9]
    !cfg_reg.source_select && cfg_reg.divider_assign && icyc_tick && !cnt_wr
    |=> counter_reg == $past(counter_reg) + 1'b1)
    else $error("instruction cycle not counted");
  a_cycle_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RL13]
    !cfg_reg.source_select && !icyc_tick && !cnt_wr |=> $stable(counter_reg))
    else $error("counted between instruction cycles");
  a_turbo_tick: assert property (@(posedge clk_in) disable iff (rst_in) // [RL13]
    turbo_in |-> icyc_tick)
    else $error("turbo cycle not every clock");

  a_presc_gate: assert property (@(posedge clk_in) disable iff (rst_in) // [RL8] [RL10]
    !cfg_reg.divider_assign && !presc_wrap_cnt && !cnt_wr |=> $stable(counter_reg))
    else $error("counter bypassed divider");
  a_presc_restart: assert property (@(posedge clk_in) disable iff (rst_in) // [RL10]
    !cfg_reg.divider_assign && cnt_tick |=> presc_reg == 8'h0)
    else $error("divider not restarted");
  a_wdt_idle: assert property (@(posedge clk_in) disable iff (rst_in) // [RL8] [RL9]
    !wdt_timeout_in |=> !wdt_reset_out)
    else $error("watchdog reset without timeout");
  a_wdt_presc_clear: assert property (@(posedge clk_in) disable iff (rst_in) // [RL11]
    cfg_reg.divider_assign && wdt_fire |=> presc_reg == 8'h0)
    else $error("timeout count not restarted");
  a_wdt_presc_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [RL9]
    cfg_reg.divider_assign && !wdt_timeout_in |=> $stable(presc_reg))
    else $error("timeout count moved");

  a_roll_needs_max: assert property (@(posedge clk_in) disable iff (rst_in) // [RL14]
    !cnt_max |=> !status_reg[ST_ROLL] || $past(status_reg[ST_ROLL]))
    else $error("rollover flag without wrap");
  a_wdt_status: assert property (@(posedge clk_in) disable iff (rst_in)
    wdt_fire |=> status_reg[ST_WDRST])
    else $error("watchdog reset not flagged");
  a_status_clear: assert property (@(posedge clk_in) disable iff (rst_in)
    wr && sel_st && av_in.writedata[ST_ROLL] && !rollover |=> !status_reg[ST_ROLL])
    else $error("rollover flag not cleared");
  a_irq_level_on: assert property (@(posedge clk_in) disable iff (rst_in)
    status_reg[ST_ROLL] && mask_reg[ST_ROLL] |-> irq_out)
    else $error("unmasked flag without irq");
  a_irq_level_off: assert property (@(posedge clk_in) disable iff (rst_in)
    status_reg == 2'h0 |-> !irq_out)
    else $error("irq without flag");
  a_entry_start: assert property (@(posedge clk_in) disable iff (rst_in) // [RL4]
    roll_req && !entry_busy_reg |=> entry_busy_reg)
    else $error("enabled rollover not taken");
  a_entry_single: assert property (@(posedge clk_in) disable iff (rst_in) // [RL12]
    rollover_irq_out |=> !rollover_irq_out)
    else $error("entry pulse too long");
  a_entry_compat: assert property (@(posedge clk_in) disable iff (rst_in) // [RL12] [RL13]
    !turbo_in && !cfg_reg.source_select && roll_req && !entry_busy_reg
    ##1 !turbo_in [*8] ##1 !turbo_in [*4] |-> rollover_irq_out)
    else $error("compatible entry delay wrong");

  c_rollover: cover property (@(posedge clk_in) disable iff (rst_in) rollover_irq_out);
  c_wdt_reset: cover property (@(posedge clk_in) disable iff (rst_in)
    cfg_reg.divider_assign && wdt_reset_out);
  c_ext_count: cover property (@(posedge clk_in) disable iff (rst_in)
    cfg_reg.source_select && cnt_tick);
  c_compat_count: cover property (@(posedge clk_in) disable iff (rst_in)
    !turbo_in && cnt_tick);
  c_bus_read: cover property (@(posedge clk_in) disable iff (rst_in)
    av_in.read && !waitrequest_out);
endmodule

// [rtl/cfg_pkg.sv]
// package with constants and types for the counter configuration block
// Overview of operation
// RL1: reset loads every configuration register bit with one.
// RL2: map select zero shows accumulator at address 01h, one shows the counter.
// RL3: map select may be cleared only when configuration_word_a extend enable is zero.
// RL4: interrupt disable zero lets counter rollover request an interrupt; one blocks it. Code gates only rollover_irq_out, not irq_out.
// RL5: interrupt disable may be cleared only when configuration_word_a extend enable is zero.
// RL6: source select zero counts instruction cycles; one counts external pin edges.
// RL7: polarity one counts falling edges, zero counts rising edges.
// RL8: assign zero puts divider before counter; watchdog runs undivided.
// RL9: assign one divides watchdog timeouts; counter takes every tick.
// RL10: counter divide factor is two to the power of field plus one.
// RL11: watchdog needs two to the power of field timeouts before reset.
// RL12: rollover interrupt entry waits three instruction cycles.
// RL13: instruction cycle is one clock in turbo, four in compatible mode.
// RL14: counter is eight bits, wraps to zero, rollover raised at wrap.
// RL15: external input is synchronised before edge detection.
package cfg_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_COUNTER = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'hC;
  localparam logic [7:0] CONFIG_RESET = 8'hFF;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam int unsigned BIT_MAP = 7;
  localparam int unsigned BIT_IRQ_DIS = 6;
  localparam int unsigned BIT_SRC = 5;
  localparam int unsigned BIT_POL = 4;
  localparam int unsigned BIT_ASSIGN = 3;
  localparam logic [2:0] COMPAT_DIV_LAST = 3'h3;
  localparam int unsigned ENTRY_DELAY = 3;
  localparam int unsigned ST_ROLL = 0;
  localparam int unsigned ST_WDRST = 1;

  typedef struct packed {
    logic map_select;
    logic irq_disable;
    logic source_select;
    logic polarity;
    logic divider_assign;
    logic [2:0] factor;
  } config_s;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } av_req_s;
endpackage

// [verif/pin_source.sv]
// external event source driving the count pin
`timescale 1ns/1ps
module pin_source (
  input wire logic clk_in,
  input wire logic [3:0] toggles_in,
  input wire logic go_in,
  output logic pin_out
);
  int left = 0;
  initial pin_out = 1'b0;
  // each level held four clocks, well above the synchroniser depth
  always @(posedge clk_in) begin
    if (go_in) begin
      left <= 4 * toggles_in;
    end else if (left > 0) begin
      left <= left - 1;
      if (left % 4 == 1) pin_out <= ~pin_out;
    end
  end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the counter configuration block
`timescale 1ns/1ps
module tb_top;
  import cfg_pkg::*;
  logic clk_in = 0, rst_in = 1, configuration_word_a = 1, turbo = 1, wdt = 0, go = 0;
  logic [3:0] tg = 4'h0;
  logic [7:0] acc = 8'hA5, f01, c0;
  av_req_s av = '0;
  logic [31:0] rdata, d;
  logic wreq, pin, map, wrst, rirq, irq;
  int n_errors = 0, n_tests = 0, nw = 0, k, i;
  always #20 clk_in = ~clk_in;
  always @(posedge clk_in) if (wrst === 1'b1) nw++;
  pin_source src (.clk_in(clk_in), .toggles_in(tg), .go_in(go), .pin_out(pin));
  counter_config uut (.clk_in(clk_in), .rst_in(rst_in), .av_in(av), .readdata_out(rdata),
    .waitrequest_out(wreq), .configuration_word_a_extend_enable_in(configuration_word_a), .turbo_in(turbo),
    .count_pin_in(pin), .wdt_timeout_in(wdt), .accumulator_in(acc), .map_select_out(map),
    .file01_out(f01), .wdt_reset_out(wrst), .rollover_irq_out(rirq), .irq_out(irq));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic w, input logic [31:0] wd);
    int j;
    av <= '{a, !w, w, wd};
    for (j = 0; j < 50; j++) begin
      @(posedge clk_in);
      if (wreq === 1'b0) break;
    end
    d = rdata;
    av <= '0;
    @(posedge clk_in);
    if (j == 50) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic t_reset();
    bus(OFS_CONFIG, 0, 0);
    chk("config", 32'hFF, d);
    chk("map", 1'b1, map);
    bus(OFS_MASK, 0, 0);
    chk("mask", 32'h0, d);
    chk("irq", 1'b0, irq);
  endtask
  task automatic t_protect();
    bus(OFS_CONFIG, 1, 32'h00);
    bus(OFS_CONFIG, 0, 0);
    chk("guarded", 32'hC0, d);
    configuration_word_a <= 1'b0;
    bus(OFS_CONFIG, 1, 32'h3F);
    bus(OFS_CONFIG, 0, 0);
    chk("config", 32'h3F, d);
    chk("file01", acc, f01);
    chk("map", 1'b0, map);
    bus(4'h2, 1, 32'h55);
    bus(4'h2, 0, 0);
    chk("unmapped", 32'h0, d);
  endtask
  task automatic t_rate();
    for (int f = 0; f < 8; f++) begin
      bus(OFS_CONFIG, 1, 32'hC0 | f);
      c0 = f01;
      pause(8 << f);
      chk("divided", 8'h04, f01 - c0);
    end
    bus(OFS_CONFIG, 1, 32'hCF);
    c0 = f01;
    pause(10);
    chk("undivided", 8'd10, f01 - c0);
    turbo <= 1'b0;
    bus(OFS_CONFIG, 1, 32'hCF);
    c0 = f01;
    pause(40);
    chk("compat", 8'd10, f01 - c0);
    turbo <= 1'b1;
  endtask
  task automatic burst(input logic [7:0] cfg, input logic [3:0] n, input logic [7:0] e);
    bus(OFS_CONFIG, 1, cfg);
    c0 = f01;
    tg <= n;
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    pause(4 * n + 8);
    chk("pin count", e, f01 - c0);
  endtask
  task automatic t_wdt();
    for (int f = 0; f < 5; f++) begin
      bus(OFS_CONFIG, 1, f < 4 ? 32'hC8 | f : 32'hC0);
      nw = 0;
      repeat (f < 4 ? 2 << f : 3) begin
        wdt <= 1'b1;
        @(posedge clk_in);
        wdt <= 1'b0;
        pause(2);
      end
      pause(4);
      chk("wdt resets", f < 4 ? 2 : 3, nw);
    end
  endtask
  task automatic t_irq();
    bus(OFS_CONFIG, 1, 32'h88);
    bus(OFS_MASK, 1, 32'h0);
    bus(OFS_STATUS, 1, 32'h3);
    bus(OFS_COUNTER, 1, 32'hF0);
    c0 = 8'h00;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (c0 === 8'hFF && f01 === 8'h00) break;
      c0 = f01;
    end
    chk("wrap seen", 1'b1, i < 300);
    for (k = 1; k < 10 && rirq !== 1'b1; k++) @(posedge clk_in);
    chk("entry delay", 3, k);
    bus(OFS_STATUS, 0, 0);
    chk("status", 32'h1, d & 32'h1);
    chk("masked irq", 1'b0, irq);
    bus(OFS_MASK, 1, 32'h1);
    chk("irq", 1'b1, irq);
    bus(OFS_STATUS, 1, 32'h1);
    chk("cleared irq", 1'b0, irq);
    bus(OFS_CONFIG, 1, 32'hC8);
    k = 0;
    repeat (300) @(posedge clk_in) if (rirq === 1'b1) k++;
    chk("disabled entry", 0, k);
  endtask
  initial begin
    pause(6);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_protect();
    t_rate();
    burst(8'hE8, 4'd3, 8'd2);
    burst(8'hF8, 4'd1, 8'd1);
    t_wdt();
    t_irq();
    print_verdict();
  end
endmodule
